//--- include/dtmr_regs.svh
`ifndef DTMR_REGS_SVH
`define DTMR_REGS_SVH
// Register offsets (plain port, 4-bit address)
`define DTMR_OFF_CTRL0    4'h0
`define DTMR_OFF_CMP0     4'h1
`define DTMR_OFF_CTRL1    4'h2
`define DTMR_OFF_CMP1     4'h3
`define DTMR_OFF_IRQ_STAT 4'h4
`define DTMR_OFF_IRQ_MASK 4'h5
`define DTMR_OFF_COUNT0   4'h6
`define DTMR_OFF_COUNT1   4'h7
// Channel control fields
`define DTMR_CTRL_MODE_LSB 0
`define DTMR_CTRL_RUN_BIT  3
`define DTMR_CTRL_CLK_LSB  4
`define DTMR_CTRL_FF_BIT   7
// Reset values
`define DTMR_CTRL_RST      8'h00
`define DTMR_CMP_RST       8'hFF
`define DTMR_MASK_RST      2'h0
// Prescaler stage taps (bit index of a free-running divider)
`define DTMR_TAP_DIV2048   10
`define DTMR_TAP_DIV128    6
`define DTMR_TAP_DIV32     4
`define DTMR_TAP_DIV8      2
`define DTMR_TAP_DIV2      0
`define DTMR_PRE_W         11
`endif

//--- include/dtmr_pkg.sv
package dtmr_pkg;
    // Mode select field encodings
    typedef enum logic [2:0] {
        DTMR_MODE_TIMER = 3'h0,
        DTMR_MODE_DIV   = 3'h1
    } dtmr_mode_t;

    // Clock select field encodings
    typedef enum logic [2:0] {
        DTMR_CK_D2048 = 3'h0,
        DTMR_CK_D128  = 3'h1,
        DTMR_CK_D32   = 3'h2,
        DTMR_CK_D8    = 3'h3,
        DTMR_CK_SLOW  = 3'h4,
        DTMR_CK_D2    = 3'h5,
        DTMR_CK_FULL  = 3'h6,
        DTMR_CK_PIN   = 3'h7
    } dtmr_clk_t;

    // Channel control register layout
    typedef struct packed {
        logic       ff_preset;
        dtmr_clk_t  clk_sel;
        logic       run;
        logic [2:0] mode;
    } dtmr_ctrl_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dtmr_bus_t;
endpackage : dtmr_pkg

//--- verilog/dtmr_top.sv
// Overview of operation
// - Timer mode counts internal clock; match raises interrupt, clears, resumes.
// - Compare register has no shadow; a write takes effect at once.
// - Event mode counts input falling edges; match interrupts, clears, counts on.
// - Divider mode toggles flip-flop on match, clears, interrupts; 50% square wave.
// - Divider pin always shows inverse of the output flip-flop.
// - Software loads the flip-flop via preset bit; reset clears it to 0.
// - Stop holds pin level; change flip-flop only in a later write.
// - Mode 000 is timer/event counter, 001 is divider output.
// - Run bit 0 stops and clears the counter; 1 starts counting.
//
// Local design decisions: the placing of the registers and strobed register access.
`include "dtmr_regs.svh"
`default_nettype none
module dtmr_top
    import dtmr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       clk_en_i,
    input  wire dtmr_bus_t  bus_i,
    output var  logic [7:0] rdata_o,
    input  wire logic       slow_clk_i,
    input  wire logic [1:0] event_input_pin_i,
    output var  logic [1:0] divider_output_pin_o,
    output var  logic       irq_o
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] ev_s1_q;
    logic [1:0] ev_s2_q;
    logic [1:0] ev_s3_q;
    logic       sl_s1_q;
    logic       sl_s2_q;
    logic       sl_s3_q;

    // Pins are asynchronous: two flops before use, a third for edge detection
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ev_s1_q <= 2'h3;
            ev_s2_q <= 2'h3;
            ev_s3_q <= 2'h3;
            sl_s1_q <= 1'h0;
            sl_s2_q <= 1'h0;
            sl_s3_q <= 1'h0;
        end
        else if (clk_en_i)
        begin
            ev_s1_q <= event_input_pin_i;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
            sl_s1_q <= slow_clk_i;
            sl_s2_q <= sl_s1_q;
            sl_s3_q <= sl_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic [`DTMR_PRE_W-1:0] pre_q;
    logic [`DTMR_PRE_W-1:0] pre_d;
    logic [`DTMR_PRE_W-1:0] pre_rise;
    logic                   slow_rise;

    assign pre_d     = pre_q + `DTMR_PRE_W'(1);
    assign pre_rise  = pre_d & ~pre_q;
    assign slow_rise = sl_s2_q & ~sl_s3_q;

    // Free-running divider; each bit's rising edge is one tap tick
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pre_q <= '0;
        else if (clk_en_i)
            pre_q <= pre_d;
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    dtmr_ctrl_t ctrl_q [2];
    logic [7:0] cmp_q  [2];
    logic [7:0] cnt_q  [2];
    logic [1:0] ff_q;
    logic [1:0] match;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic       wr_ctrl [2];
    logic       wr_cmp  [2];

    assign wr_ctrl[0] = bus_i.wr && bus_i.addr == `DTMR_OFF_CTRL0;
    assign wr_ctrl[1] = bus_i.wr && bus_i.addr == `DTMR_OFF_CTRL1;
    assign wr_cmp[0]  = bus_i.wr && bus_i.addr == `DTMR_OFF_CMP0;
    assign wr_cmp[1]  = bus_i.wr && bus_i.addr == `DTMR_OFF_CMP1;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_chan
            logic tick;
            logic running;
            logic is_div;

            assign running = ctrl_q[g].run;
            assign is_div  = ctrl_q[g].mode == DTMR_MODE_DIV;

            // Clock source selection
            always_comb
            begin
                unique case (ctrl_q[g].clk_sel)
                    DTMR_CK_D2048: tick = pre_rise[`DTMR_TAP_DIV2048];
                    DTMR_CK_D128:  tick = pre_rise[`DTMR_TAP_DIV128];
                    DTMR_CK_D32:   tick = pre_rise[`DTMR_TAP_DIV32];
                    DTMR_CK_D8:    tick = pre_rise[`DTMR_TAP_DIV8];
                    DTMR_CK_SLOW:  tick = slow_rise;
                    DTMR_CK_D2:    tick = pre_rise[`DTMR_TAP_DIV2];
                    DTMR_CK_FULL:  tick = 1'b1;
                    DTMR_CK_PIN:   tick = ev_s3_q[g] & ~ev_s2_q[g];
                endcase
            end

            // Match uses the live compare value, no shadow stage
            assign match[g] = running && tick && cnt_q[g] == cmp_q[g];

            // Control and compare registers
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    ctrl_q[g] <= dtmr_ctrl_t'(`DTMR_CTRL_RST);
                    cmp_q[g]  <= `DTMR_CMP_RST;
                end
                else if (clk_en_i)
                begin
                    if (wr_ctrl[g])
                        ctrl_q[g] <= dtmr_ctrl_t'(bus_i.wdata);
                    if (wr_cmp[g])
                        cmp_q[g] <= bus_i.wdata;
                end
            end

            // Up-counter: independent per channel
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    cnt_q[g] <= 8'h00;
                else if (clk_en_i)
                begin
                    if (!running)
                        cnt_q[g] <= 8'h00;
                    else if (match[g])
                        cnt_q[g] <= 8'h00;
                    else if (tick)
                        cnt_q[g] <= cnt_q[g] + 8'h01;
                end
            end

            // Output flip-flop: preset by software while stopped, toggles on match in divider mode only
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    ff_q[g] <= 1'b0;
                else if (clk_en_i)
                begin
                    if (wr_ctrl[g] && !bus_i.wdata[`DTMR_CTRL_RUN_BIT] && !running)
                        ff_q[g] <= bus_i.wdata[`DTMR_CTRL_FF_BIT];
                    else if (wr_ctrl[g] && !running)
                        ff_q[g] <= bus_i.wdata[`DTMR_CTRL_FF_BIT];
                    else if (match[g] && is_div)
                        ff_q[g] <= ~ff_q[g];
                end
            end

            // Pin is the inverse of the flip-flop, registered
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    divider_output_pin_o[g] <= 1'b1;
                else if (clk_en_i)
                    divider_output_pin_o[g] <= ~ff_q[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Sticky status; a match in the clearing cycle wins
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            stat_q <= 2'h0;
            mask_q <= `DTMR_MASK_RST;
        end
        else if (clk_en_i)
        begin
            if (bus_i.wr && bus_i.addr == `DTMR_OFF_IRQ_MASK)
                mask_q <= bus_i.wdata[1:0];
            if (bus_i.wr && bus_i.addr == `DTMR_OFF_IRQ_STAT)
                stat_q <= (stat_q & ~bus_i.wdata[1:0]) | match;
            else
                stat_q <= stat_q | match;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            irq_o <= 1'b0;
        else if (clk_en_i)
            irq_o <= |(stat_q & mask_q);
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Data valid only in the cycle after the strobe; otherwise zero
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_o <= 8'h00;
        else if (clk_en_i)
        begin
            rdata_o <= 8'h00;
            if (bus_i.rd)
            begin
                unique case (bus_i.addr)
                    `DTMR_OFF_CTRL0:    rdata_o <= {ff_q[0], ctrl_q[0][6:0]};
                    `DTMR_OFF_CMP0:     rdata_o <= cmp_q[0];
                    `DTMR_OFF_CTRL1:    rdata_o <= {ff_q[1], ctrl_q[1][6:0]};
                    `DTMR_OFF_CMP1:     rdata_o <= cmp_q[1];
                    `DTMR_OFF_IRQ_STAT: rdata_o <= {6'h00, stat_q};
                    `DTMR_OFF_IRQ_MASK: rdata_o <= {6'h00, mask_q};
                    `DTMR_OFF_COUNT0:   rdata_o <= cnt_q[0];
                    `DTMR_OFF_COUNT1:   rdata_o <= cnt_q[1];
                    default:            rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule : dtmr_top
`default_nettype wire

//--- verif/dtmr_props.sv
`default_nettype none
module dtmr_props
    import dtmr_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic       clk_en_i,
    input wire dtmr_bus_t  bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic       slow_clk_i,
    input wire logic [1:0] event_input_pin_i,
    input wire logic [1:0] divider_output_pin_o,
    input wire logic       irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------
    // Shadow of software writes
    // ----------
    logic        run0_q;
    logic [1:0]  quiet0_q;
    logic [1:0]  mask_q;
    wire  [1:0]  dpin  = divider_output_pin_o;
    wire  [15:0] rd_at = bus_i.rd ? 16'h0001 << bus_i.addr : 16'h0000;
    wire  [15:0] wr_at = bus_i.wr ? 16'h0001 << bus_i.addr : 16'h0000;
    // Quiet time after a control write, since a stop may meet a match
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            run0_q   <= 1'b0;
            quiet0_q <= 2'h0;
            mask_q   <= 2'h0;
        end
        else if (clk_en_i)
        begin
            if (wr_at[0])
                run0_q <= bus_i.wdata[3];
            if (wr_at[5])
                mask_q <= bus_i.wdata[1:0];
            quiet0_q <= wr_at[0] ? 2'h0 : quiet0_q + {1'b0, quiet0_q != 2'h3};
        end
    end
    // ----------
    // Properties
    // ----------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i || !clk_en_i);
    chk_rd_idle: assert property ($past(clk_en_i) && !$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero");
    chk_ff_inv0: assert property (rd_at[0] |=> rdata_o[7] != dpin[0])
        else $error("pin 0 not inverse of flip-flop");
    chk_ff_inv1: assert property (rd_at[2] |=> rdata_o[7] != dpin[1])
        else $error("pin 1 not inverse of flip-flop");
    chk_stop_hold: assert property (!run0_q && quiet0_q == 2'h3 |-> $stable(dpin[0]))
        else $error("stopped pin moved");
    chk_mask_off: assert property (wr_at[5] && bus_i.wdata[1:0] == 2'h0 ##1 !wr_at[5]
        |=> !irq_o) else $error("masked interrupt still high");
    chk_irq_cause: assert property ($rose(irq_o) |-> mask_q != 2'h0)
        else $error("interrupt without mask bit");
    chk_cmp_back: assert property (wr_at[1] ##1 !bus_i.wr ##1 rd_at[1]
        |=> rdata_o == $past(bus_i.wdata, 3)) else $error("compare write not seen");
    chk_stop_clr: assert property (wr_at[0] && !bus_i.wdata[3] ##1 !bus_i.wr ##1 rd_at[6]
        |=> rdata_o == 8'h00) else $error("count not cleared by stop");
    cov_irq: cover property ($rose(irq_o));
    cov_div: cover property ($changed(dpin[1]));
    cov_evt: cover property ($fell(event_input_pin_i[0]));
endmodule : dtmr_props
bind dtmr_top dtmr_props dtmr_props_inst (.clk_i, .resetn_i, .clk_en_i, .bus_i, .rdata_o,
    .slow_clk_i, .event_input_pin_i, .divider_output_pin_o, .irq_o);
`default_nettype wire

//--- verif/dtmr_evsrc.sv
`default_nettype none
module dtmr_evsrc #(
    parameter int HOLD = 3
) (
    input  wire logic       clk_i,
    output var  logic [1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------
    // External event source
    // ----------
    // Lines idle high, as a pulled-up source would leave them
    initial pin_o = 2'b11;
    // Each level held past two machine cycles so the filter sees it
    task automatic pulses(input int ch, input int cnt);
        repeat (cnt)
        begin
            @(posedge clk_i);
            pin_o[ch] <= 1'b0;
            repeat (HOLD) @(posedge clk_i);
            pin_o[ch] <= 1'b1;
            repeat (HOLD) @(posedge clk_i);
        end
    endtask : pulses
endmodule : dtmr_evsrc
`default_nettype wire

//--- verif/dtmr_tb.sv
`default_nettype none
module testbench
    import dtmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_i;
    logic       resetn_i;
    dtmr_bus_t  bus_i;
    wire  [7:0] rdata_o;
    wire  [1:0] ev_pin;
    wire  [1:0] div_pin;
    wire        irq_o;
    wire  [2:0] obs = {irq_o, div_pin};
    logic       lvl;
    int         num_errors;
    int         n_checks;
    int         n;
    // ----------
    // Block and event source
    // ----------
    dtmr_top dtmr_top_inst (.clk_i, .resetn_i, .clk_en_i(1'b1), .bus_i, .rdata_o,
        .slow_clk_i(1'b0), .event_input_pin_i(ev_pin), .divider_output_pin_o(div_pin), .irq_o);
    dtmr_evsrc dtmr_evsrc_inst (.clk_i, .pin_o(ev_pin));
    // 25 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // ----------
    // Bus and compare tasks
    // ----------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1 chk(rdata_o, exp);
    endtask : rc
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic report_and_stop();
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // Edges until an observed output changes; bounded so a stuck output ends the run
    task automatic tgl(input int i, output int k);
        logic p;
        p = obs[i];
        k = 0;
        while (obs[i] === p)
        begin
            @(posedge clk_i);
            #1 k++;
            if (k > 500)
            begin
                num_errors++;
                report_and_stop();
            end
        end
    endtask : tgl
    // ----------
    // Main sequence
    // ----------
    initial
    begin
        resetn_i = 1'b0;
        bus_i = '0;
        num_errors = 0;
        n_checks = 0;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        rc(4'h0, 8'h00);
        rc(4'h1, 8'hFF);
        chk({6'h00, div_pin}, 8'h03);
        rc(4'hF, 8'h00);
        wr(4'h1, 8'h03);
        rc(4'h1, 8'h03);
        // Timer on every clock, then mask, unmask, stop and clear
        wr(4'h5, 8'h01);
        wr(4'h0, 8'h68);
        tgl(2, n);
        rc(4'h4, 8'h01);
        wr(4'h5, 8'h00);
        cyc(2);
        chk({7'h00, irq_o}, 8'h00);
        wr(4'h5, 8'h01);
        cyc(2);
        chk({7'h00, irq_o}, 8'h01);
        wr(4'h0, 8'h60);
        rc(4'h6, 8'h00);
        wr(4'h4, 8'h01);
        cyc(2);
        chk({7'h00, irq_o}, 8'h00);
        // Divider on channel 1: half period is compare plus one clocks
        wr(4'h3, 8'h02);
        wr(4'h2, 8'h69);
        tgl(1, n);
        tgl(1, n);
        chk(8'(n), 8'h03);
        tgl(1, n);
        chk(8'(n), 8'h03);
        chk({7'h00, div_pin[0]}, 8'h01);
        wr(4'h2, 8'h61);
        cyc(3);
        lvl = div_pin[1];
        cyc(8);
        chk({7'h00, div_pin[1]}, {7'h00, lvl});
        rc(4'h2, {~lvl, 7'h61});
        wr(4'h2, 8'hE1);
        cyc(3);
        chk({7'h00, div_pin[1]}, 8'h00);
        wr(4'h2, 8'h61);
        cyc(3);
        chk({7'h00, div_pin[1]}, 8'h01);
        // Event counting on pin falling edges
        wr(4'h4, 8'h03);
        wr(4'h1, 8'h02);
        wr(4'h0, 8'h78);
        dtmr_evsrc_inst.pulses(0, 2);
        cyc(2);
        rc(4'h6, 8'h02);
        dtmr_evsrc_inst.pulses(0, 1);
        cyc(2);
        rc(4'h6, 8'h00);
        rc(4'h4, 8'h01);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
